// File: fsr_regs.svh
// Opcodes, status bit positions, reset values and busy counts of the
// flash status bank. Definitions only; included by the top module.
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

// Read commands for the three status bytes.
`define FSR_READ_STATUS_ONE_CMD     8'h05
`define FSR_READ_STATUS_TWO_CMD_A   8'h09
`define FSR_READ_STATUS_TWO_CMD_B   8'h35
`define FSR_READ_STATUS_THREE_CMD_A 8'h95
`define FSR_READ_STATUS_THREE_CMD_B 8'h15

// Latch and status write commands.
`define FSR_WRITE_ENABLE_CMD        8'h06
`define FSR_WRITE_DISABLE_CMD       8'h04
`define FSR_STATUS_WRITE_CMD        8'h01

// Program, erase and suspend commands.
`define FSR_PAGE_PROGRAM_CMD        8'h02
`define FSR_QUAD_PAGE_PROGRAM_CMD   8'h32
`define FSR_SECTOR_ERASE_CMD        8'h20
`define FSR_HALF_BLOCK_ERASE_CMD    8'h52
`define FSR_BLOCK_ERASE_CMD         8'hd8
`define FSR_CHIP_ERASE_CMD          8'hc7
`define FSR_SUSPEND_CMD             8'h75
`define FSR_RESUME_CMD              8'h7a

// Field positions in the second status byte.
`define FSR_S2_ERASE_SUSP 7
`define FSR_S2_COMPL      6
`define FSR_S2_LOCK_HI    5
`define FSR_S2_LOCK_LO    3
`define FSR_S2_PROG_SUSP  2
`define FSR_S2_QUAD_EN    1

// Reset values: protect bits clear, quad enable set, third byte zero.
`define FSR_CTL_RST   6'h00
`define FSR_S2_RST    8'h02
`define FSR_S3_RST    8'h00

// Busy lengths in clk_in cycles, and protection unit sizes as shifts.
`define FSR_WRSTAT_CYCLES 16'h0010
`define FSR_PROG_CYCLES   16'h0040
`define FSR_ERASE_CYCLES  16'h0100
`define FSR_SECT_SHIFT    5'h0c
`define FSR_BLOCK_SHIFT   5'h10

`endif

// File: fsr_pkg.sv
// Types shared by the flash status bank files.
// Assumes the opcode and field constants come from fsr_regs.svh.
package fsr_pkg;

  // Core sequencer states, one-hot.
  typedef enum logic [2:0] {
    fsr_st_idle = 3'b001,
    fsr_st_busy = 3'b010,
    fsr_st_susp = 3'b100
  } fsr_state_e;

  // Kind of internal write cycle that is running.
  typedef enum logic [1:0] {
    fsr_k_wrstat = 2'h0,
    fsr_k_prog   = 2'h1,
    fsr_k_erase  = 2'h2
  } fsr_kind_e;

  // One frame as collected on the link: opcode, three bytes after it,
  // byte count, whole-byte flag and a frame sequence bit.
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [2:0] cnt;
    logic       aligned;
    logic       seq;
  } fsr_rec_s;

  // The three status bytes as handed to the link.
  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
    logic [7:0] three;
  } fsr_snap_s;

endpackage

// File: fsr_sync.sv
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level or a toggle that changes slowly.
`timescale 1ns/1ps
module fsr_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  // First stage; read only by the second stage.
  logic [W-1:0] meta_reg;
  // Second stage, safe for any logic.
  logic [W-1:0] safe_reg;

  // Both stages load RST, the idle level of each input, so that a pin
  // that idles high does not show a false edge after reset.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_reg <= RST;
      safe_reg <= RST;
    end else begin
      meta_reg <= d_in;
      safe_reg <= meta_reg;
    end
  end

  assign q_out = safe_reg;

endmodule

// File: fsr_top.sv
// Status register bank of a serial flash with its serial read path.
// Assumes a host drives sclk_link_in and cs_n_in in SPI mode 0 or 3.
`timescale 1ns/1ps
`include "fsr_regs.svh"
module fsr_top #(
  parameter int CNT_W = 16
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       sclk_link_in,
  input  wire logic       cs_n_in,
  input  wire logic       di_in,
  input  wire logic       wp_n_in,
  output logic            do_out,
  output logic            do_oe_n_out,
  output logic            busy_out,
  output logic [7:0]      status_one_out,
  output logic [7:0]      status_two_out
);

  // Maps a read opcode to the byte it selects, zero for none.
  function automatic logic [1:0] rd_decode(input logic [7:0] op);
    logic [1:0] sel;
    sel = 2'h0;
    if (op == `FSR_READ_STATUS_ONE_CMD) begin
      sel = 2'h1;
    end else if (op == `FSR_READ_STATUS_TWO_CMD_A ||
                 op == `FSR_READ_STATUS_TWO_CMD_B) begin
      sel = 2'h2;
    end else if (op == `FSR_READ_STATUS_THREE_CMD_A ||
                 op == `FSR_READ_STATUS_THREE_CMD_B) begin
      sel = 2'h3;
    end
    return sel;
  endfunction

  // Picks one status byte from the link copy.
  function automatic logic [7:0] sel_byte(input logic [1:0] sel,
                                          input fsr_pkg::fsr_snap_s s);
    logic [7:0] b;
    case (sel)
      2'h1:    b = s.one;
      2'h2:    b = s.two;
      2'h3:    b = s.three;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // True when addr falls inside the area that the protect bits select.
  function automatic logic prot_area(input logic [23:0] addr,
                                     input logic [5:0]  ctl,
                                     input logic        compl);
    logic [4:0]  sh;
    logic [24:0] lim;
    logic        near;
    logic        hit;
    // Boot lock picks the unit size.
    sh = (ctl[4] ? `FSR_SECT_SHIFT : `FSR_BLOCK_SHIFT)
         + {2'h0, ctl[2:0]} - 5'h01;
    lim = 25'h0000001 << sh;
    // Top/bottom picks which end of the array is counted from.
    near = ctl[3] ? ({1'b0, addr} < lim) : ({1'b0, ~addr} < lim);
    hit = (ctl[2:0] == 3'h0) ? 1'b0 :
          (ctl[2:0] == 3'h7) ? 1'b1 : near;
    return hit ^ compl;
  endfunction

  // ---------------- Link side, on the host's serial clock -------------

  // Bit and frame state clears whenever select is high.
  logic                link_rst_n;
  assign link_rst_n = reset_n_in & ~cs_n_in;

  logic [2:0]          bit_cnt_reg;   // Bits of the current byte.
  logic                started_reg;   // A rising edge has been seen.
  logic [1:0]          rd_sel_reg;    // Byte being read back, 0 none.
  logic [7:0]          out_byte_reg;  // Byte now being shifted out.
  logic [6:0]          shift_reg;     // Incoming bits.
  fsr_pkg::fsr_rec_s   rec_reg;       // Record of the current frame.
  fsr_pkg::fsr_snap_s  snap_reg;      // Link copy of the status.
  fsr_pkg::fsr_snap_s  pub_reg;       // Core copy offered to the link.
  logic                ack_tgl_reg;   // Link has taken pub_reg.
  logic                req_tgl_reg;   // Core has a fresh pub_reg.
  logic                req_s;         // req_tgl_reg in link time.
  logic                do_reg;        // Serial output bit.
  logic                do_oe_n_reg;   // Output enable, low drives.

  logic                byte_done;
  logic [7:0]          in_byte;
  logic [2:0]          pos;
  logic [2:0]          cnt_next;
  logic [1:0]          rd_sel_next;

  assign byte_done   = (bit_cnt_reg == 3'h7);
  assign in_byte     = {shift_reg, di_in};
  // Byte position restarts at zero on the frame's first edge.
  assign pos         = started_reg ? rec_reg.cnt : 3'h0;
  assign cnt_next    = (byte_done && pos != 3'h7) ? pos + 3'h1 : pos;
  assign rd_sel_next = (byte_done && pos == 3'h0) ? rd_decode(in_byte)
                                                  : rd_sel_reg;

  fsr_sync #(.W(1)) u_sync_link (
    .clk_in     (sclk_link_in),
    .reset_n_in (reset_n_in),
    .d_in       (req_tgl_reg),
    .q_out      (req_s)
  );

  // Per-frame counters; reset by select so each frame starts clean.
  always_ff @(posedge sclk_link_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg  <= 3'h0;
      started_reg  <= 1'b0;
      rd_sel_reg   <= 2'h0;
      out_byte_reg <= 8'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      started_reg <= 1'b1;
      rd_sel_reg  <= rd_sel_next;
      // Reload each byte so a held read tracks the latest value.
      if (byte_done) begin
        out_byte_reg <= sel_byte(rd_sel_next, snap_reg);
      end
    end
  end

  // Frame record survives select rising so the core can take it.
  always_ff @(posedge sclk_link_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_reg   <= 7'h00;
      rec_reg     <= '0;
      snap_reg    <= '0;
      ack_tgl_reg <= 1'b0;
    end else begin
      shift_reg       <= in_byte[6:0];
      rec_reg.cnt     <= cnt_next;
      rec_reg.aligned <= byte_done;
      // A new sequence bit marks a frame that had clock edges.
      if (!started_reg) begin
        rec_reg.seq <= ~rec_reg.seq;
      end
      if (byte_done) begin
        case (pos)
          3'h0:    rec_reg.op <= in_byte;
          3'h1:    rec_reg.b1 <= in_byte;
          3'h2:    rec_reg.b2 <= in_byte;
          3'h3:    rec_reg.b3 <= in_byte;
          default: rec_reg.b3 <= rec_reg.b3;
        endcase
      end
      // Handshake: pub_reg is held by the core until acknowledged.
      if (req_s != ack_tgl_reg) begin
        snap_reg    <= pub_reg;
        ack_tgl_reg <= req_s;
      end
    end
  end

  // Data leaves on the falling edge, most significant bit first.
  always_ff @(negedge sclk_link_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      do_reg      <= 1'b0;
      do_oe_n_reg <= 1'b1;
    end else begin
      do_reg      <= out_byte_reg[~bit_cnt_reg];
      do_oe_n_reg <= (rd_sel_reg == 2'h0);
    end
  end

  assign do_out      = do_reg;
  assign do_oe_n_out = do_oe_n_reg;

  // ---------------- Core side, on clk_in ------------------------------

  logic [2:0]          core_s;        // {select, protect pin, ack}.
  logic                cs_s;
  logic                wp_s;
  logic                ack_s;
  logic                cs_d_reg;      // Select one cycle earlier.
  logic                seq_seen_reg;  // Sequence bit last taken.
  logic                take_reg;      // cmd_reg holds a new frame.
  fsr_pkg::fsr_rec_s   cmd_reg;       // Frame being executed.
  fsr_pkg::fsr_state_e state_reg;
  fsr_pkg::fsr_kind_e  kind_reg;
  logic [CNT_W-1:0]    timer_reg;     // Cycles left in the busy cycle.
  logic                wlatch_reg;    // Write enable latch.
  logic [5:0]          ctl_reg;       // Protect, lock, end, area bits.
  logic [7:0]          stat2_reg;     // Second status byte.
  logic [7:0]          st1_out_reg;
  logic [7:0]          st2_out_reg;

  // Select and the protect pin idle high, so their stages reset high.
  fsr_sync #(.W(3), .RST(3'b110)) u_sync_core (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .d_in       ({cs_n_in, wp_n_in, ack_tgl_reg}),
    .q_out      (core_s)
  );
  assign cs_s  = core_s[2];
  assign wp_s  = core_s[1];
  assign ack_s = core_s[0];

  // Frame end: the serial clock has stopped, so the record is quiet.
  logic frame_end;
  assign frame_end = cs_s & ~cs_d_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cs_d_reg     <= 1'b1;
      seq_seen_reg <= 1'b0;
      take_reg     <= 1'b0;
      cmd_reg      <= '0;
    end else begin
      cs_d_reg <= cs_s;
      take_reg <= frame_end && (rec_reg.seq != seq_seen_reg);
      if (frame_end) begin
        cmd_reg      <= rec_reg;
        seq_seen_reg <= rec_reg.seq;
      end
    end
  end

  // Command decode; partial bytes or wrong lengths are ignored.
  logic        cmd_ok;
  logic [7:0]  op;
  logic [2:0]  n;
  logic [23:0] addr;
  assign cmd_ok = take_reg & cmd_reg.aligned;
  assign op     = cmd_reg.op;
  assign n      = cmd_reg.cnt;
  assign addr   = {cmd_reg.b1, cmd_reg.b2, cmd_reg.b3};

  logic wren_hit, wrdi_hit, wrst_hit, prog_hit, ers_hit, chip_hit;
  logic susp_hit, res_hit;
  assign wren_hit = cmd_ok && n == 3'h1 && op == `FSR_WRITE_ENABLE_CMD;
  assign wrdi_hit = cmd_ok && n == 3'h1 && op == `FSR_WRITE_DISABLE_CMD;
  assign wrst_hit = cmd_ok && (n == 3'h2 || n == 3'h3) &&
                    op == `FSR_STATUS_WRITE_CMD;
  assign prog_hit = cmd_ok && n >= 3'h5 &&
                    (op == `FSR_PAGE_PROGRAM_CMD ||
                     op == `FSR_QUAD_PAGE_PROGRAM_CMD);
  assign ers_hit  = cmd_ok && n == 3'h4 &&
                    (op == `FSR_SECTOR_ERASE_CMD ||
                     op == `FSR_HALF_BLOCK_ERASE_CMD ||
                     op == `FSR_BLOCK_ERASE_CMD);
  assign chip_hit = cmd_ok && n == 3'h1 && op == `FSR_CHIP_ERASE_CMD;
  assign susp_hit = cmd_ok && n == 3'h1 && op == `FSR_SUSPEND_CMD;
  assign res_hit  = cmd_ok && n == 3'h1 && op == `FSR_RESUME_CMD;

  // The protect pin only counts while quad mode is off.
  logic idle, quad_en, compl, wp_low, hw_prot, area_hit;
  assign idle     = (state_reg == fsr_pkg::fsr_st_idle);
  assign quad_en  = stat2_reg[`FSR_S2_QUAD_EN];
  assign compl    = stat2_reg[`FSR_S2_COMPL];
  assign wp_low   = ~quad_en & ~wp_s;
  assign hw_prot  = ctl_reg[5] & wp_low;
  assign area_hit = prot_area(addr, ctl_reg, compl);

  // New writes start only when idle; the host is expected to poll busy.
  logic wrst_go, pe_go, chip_go, any_go, susp_go, res_go, done;
  assign wrst_go = wrst_hit & idle & wlatch_reg & ~hw_prot;
  assign pe_go   = (prog_hit | ers_hit) & idle & wlatch_reg &
                   ~area_hit;
  assign chip_go = chip_hit & idle & wlatch_reg &
                   (ctl_reg[4:0] == 5'h00) & ~compl;
  assign any_go  = wrst_go | pe_go | chip_go;
  assign susp_go = susp_hit && state_reg == fsr_pkg::fsr_st_busy &&
                   kind_reg != fsr_pkg::fsr_k_wrstat;
  assign res_go  = res_hit && state_reg == fsr_pkg::fsr_st_susp;
  assign done    = state_reg == fsr_pkg::fsr_st_busy &&
                   timer_reg == '0 && !susp_go;

  // Cycle length and kind chosen at the start of a cycle.
  logic [CNT_W-1:0]   load_val;
  fsr_pkg::fsr_kind_e kind_next;
  assign load_val  = wrst_go  ? CNT_W'(`FSR_WRSTAT_CYCLES) :
                     prog_hit ? CNT_W'(`FSR_PROG_CYCLES) :
                                CNT_W'(`FSR_ERASE_CYCLES);
  assign kind_next = wrst_go  ? fsr_pkg::fsr_k_wrstat :
                     prog_hit ? fsr_pkg::fsr_k_prog :
                                fsr_pkg::fsr_k_erase;

  // Sequencer: suspend freezes the timer, resume continues it.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= fsr_pkg::fsr_st_idle;
      kind_reg  <= fsr_pkg::fsr_k_wrstat;
      timer_reg <= '0;
    end else begin
      case (state_reg)
        fsr_pkg::fsr_st_idle: begin
          if (any_go) begin
            state_reg <= fsr_pkg::fsr_st_busy;
            kind_reg  <= kind_next;
            timer_reg <= load_val;
          end
        end
        fsr_pkg::fsr_st_busy: begin
          if (susp_go) begin
            state_reg <= fsr_pkg::fsr_st_susp;
          end else if (timer_reg == '0) begin
            state_reg <= fsr_pkg::fsr_st_idle;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        fsr_pkg::fsr_st_susp: begin
          if (res_go) begin
            state_reg <= fsr_pkg::fsr_st_busy;
          end
        end
        default: state_reg <= fsr_pkg::fsr_st_idle;
      endcase
    end
  end

  // Latch clears when a cycle completes; set and clear only when idle.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wlatch_reg <= 1'b0;
    end else if (done) begin
      wlatch_reg <= 1'b0;
    end else if (wren_hit && idle) begin
      wlatch_reg <= 1'b1;
    end else if (wrdi_hit && idle) begin
      wlatch_reg <= 1'b0;
    end
  end

  // Status bits written by the status write command and by suspend and resume.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_reg   <= `FSR_CTL_RST;
      stat2_reg <= `FSR_S2_RST;
    end else begin
      if (wrst_go) begin
        ctl_reg <= cmd_reg.b1[7:2];
      end
      if (wrst_go && n == 3'h3) begin
        // One-time bits can only be added to, never removed.
        stat2_reg[`FSR_S2_COMPL] <= compl | cmd_reg.b2[6];
        stat2_reg[`FSR_S2_LOCK_HI:`FSR_S2_LOCK_LO] <=
          stat2_reg[`FSR_S2_LOCK_HI:`FSR_S2_LOCK_LO] |
          cmd_reg.b2[5:3];
        stat2_reg[`FSR_S2_QUAD_EN] <= cmd_reg.b2[1];
      end
      if (susp_go) begin
        stat2_reg[`FSR_S2_ERASE_SUSP] <=
          (kind_reg == fsr_pkg::fsr_k_erase);
        stat2_reg[`FSR_S2_PROG_SUSP] <=
          (kind_reg == fsr_pkg::fsr_k_prog);
      end else if (res_go) begin
        stat2_reg[`FSR_S2_ERASE_SUSP] <= 1'b0;
        stat2_reg[`FSR_S2_PROG_SUSP]  <= 1'b0;
      end
      stat2_reg[0] <= 1'b0;
    end
  end

  // Assembled status bytes; busy is high only while a cycle runs.
  logic [7:0] sr1, sr2;
  assign sr1 = {ctl_reg, wlatch_reg,
                state_reg == fsr_pkg::fsr_st_busy};
  assign sr2 = {stat2_reg[7:1], 1'b0};

  // Offers fresh status to the link whenever the last offer is taken;
  // reads never wait on the sequencer.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pub_reg     <= '0;
      req_tgl_reg <= 1'b0;
      st1_out_reg <= 8'h00;
      st2_out_reg <= 8'h00;
    end else begin
      if (ack_s == req_tgl_reg) begin
        pub_reg     <= {sr1, sr2, `FSR_S3_RST};
        req_tgl_reg <= ~req_tgl_reg;
      end
      st1_out_reg <= sr1;
      st2_out_reg <= sr2;
    end
  end

  assign status_one_out = st1_out_reg;
  assign status_two_out = st2_out_reg;
  assign busy_out       = st1_out_reg[0];

  // ---------------- Checks -------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_latch_gate: assert property (any_go |-> wlatch_reg)
    else $error("write cycle started without latch");
  a_busy_start: assert property (any_go |=> sr1[0] ##1 sr1[0])
    else $error("busy not raised after cycle start");
  a_hw_freeze: assert property (
    (wrst_hit && hw_prot && idle) |=> $stable(ctl_reg))
    else $error("protect bits changed under hardware protect");
  a_compl_once: assert property (compl |=> compl)
    else $error("complement bit cleared");
  a_lock_once: assert property (
    (stat2_reg[5:3] & ~$past(stat2_reg[5:3])) == 3'h0 ||
    $past(wrst_go))
    else $error("security lock set outside status write");
  a_chip_guard: assert property (
    (chip_hit && idle && (ctl_reg[4:0] != 5'h00 || compl)) |=> idle)
    else $error("chip erase started with protection set");
  a_area_refuse: assert property (
    ((prog_hit || ers_hit) && idle && area_hit) |=> idle)
    else $error("program or erase started in protected area");
  a_erase_susp: assert property (
    (susp_go && kind_reg == fsr_pkg::fsr_k_erase)
    |=> stat2_reg[7] && !sr1[0])
    else $error("erase suspend flag not set");
  a_prog_resume: assert property (
    (res_go && stat2_reg[2]) |=> !stat2_reg[2] && sr1[0])
    else $error("program suspend flag not cleared on resume");
  a_cycle_end: assert property (
    done |=> !wlatch_reg && !sr1[0])
    else $error("latch or busy left set after cycle");

endmodule

// File: fsr_host.sv
// Host serial controller model for the flash status bank bench.
// Assumes the bench calls frame() with clk_in-aligned starts.
`timescale 1ns/1ps
module fsr_host (
  output logic       sclk_out,
  output logic       cs_n_out,
  output logic       di_out,
  input  wire logic  do_in,
  output logic [7:0] rx_out,
  output logic       rx_stb_out
);
  // Serial clock stands low and select high between frames.
  initial begin
    sclk_out   = 1'b0;
    cs_n_out   = 1'b1;
    di_out     = 1'b0;
    rx_out     = 8'h00;
    rx_stb_out = 1'b0;
  end

  // Sends n bytes of tx MSB first, then clocks k read bytes out.
  // Each read byte is published by toggling rx_stb_out.
  task automatic frame(input logic [39:0] tx, input int n, input int k);
    logic [7:0] b;
    b = 8'h00;
    cs_n_out = 1'b0;
    for (int i = 0; i < 8 * (n + k); i++) begin
      // Once the command is sent the data line toggles, never holds.
      di_out = (i < 8 * n) ? tx[39 - i] : ~di_out;
      #6 sclk_out = 1'b1;
      b = {b[6:0], do_in};
      if (i >= 8 * n && i % 8 == 7) begin
        rx_out     = b;
        rx_stb_out = ~rx_stb_out;
      end
      #6 sclk_out = 1'b0;
    end
    #6 cs_n_out = 1'b1;
    di_out = ~di_out;
  endtask
endmodule

// File: flash_status_register_read_tb.sv
// Self-checking bench for the flash status bank.
// Assumes fsr_top, fsr_host and the shared package are compiled first.
`timescale 1ns/1ps
module flash_status_register_read_tb;
  logic        clk_in, reset_n_in, wp_n_in, sclk, cs_n, di;
  logic        do_out, do_oe_n_out, busy_out, rx_stb;
  logic [7:0]  s1, s2, rx, v, m;
  logic [31:0] seed;
  logic [15:0] q[$]; // Expected read bytes: mask then value.
  int          error_cnt = 0;
  int          n_compared = 0;

  fsr_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .sclk_link_in(sclk), .cs_n_in(cs_n), .di_in(di), .wp_n_in(wp_n_in),
    .do_out(do_out), .do_oe_n_out(do_oe_n_out), .busy_out(busy_out),
    .status_one_out(s1), .status_two_out(s2));
  // A released data line shows the inverse of its last bit, so a read
  // that is taken while the output is disabled cannot pass by luck.
  fsr_host host (.sclk_out(sclk), .cs_n_out(cs_n), .di_out(di),
    .do_in(do_oe_n_out ? ~do_out : do_out), .rx_out(rx),
    .rx_stb_out(rx_stb));

  // Core clock, 50 ns period.
  always #25 clk_in = ~clk_in;

  // Compares one value and counts it.
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask

  // Prints the verdict and stops.
  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Each read byte is matched against the oldest note. The mask has its
  // own variable so that the stimulus value v is never disturbed.
  always @(rx_stb) begin
    if (q.size() > 0) begin
      m = q[0][15:8];
      check("read_byte", rx & m, q[0][7:0] & m);
      void'(q.pop_front());
    end
  end

  // One xorshift step for the random stimulus.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction

  // One frame started just after a core edge, then the select gap.
  task automatic cmd(logic [39:0] tx, int n, int k);
    @(posedge clk_in);
    #2 host.frame(tx, n, k);
    repeat (5) @(posedge clk_in);
  endtask

  // Read with two settling bytes that are not judged.
  task automatic rd(logic [7:0] op, logic [7:0] m, logic [7:0] e);
    q.push_back(16'h0000);
    q.push_back(16'h0000);
    q.push_back({m, e});
    cmd({op, 32'h0}, 1, 3);
  endtask

  // Bounded poll of busy; running out is a failure.
  task automatic idle;
    for (int i = 0; i <= 2000; i++) begin
      @(posedge clk_in);
      #1;
      if (busy_out === 1'b0) return;
    end
    error_cnt++;
    end_sim();
  endtask

  // Latch set, then a status write of both bytes.
  task automatic wrs(logic [7:0] a, logic [7:0] b);
    cmd(40'h06_0000_0000, 1, 0);
    cmd({8'h01, a, b, 16'h0}, 3, 0);
    idle();
  endtask

  initial begin
    clk_in = 1'b0;
    reset_n_in = 1'b0;
    wp_n_in = 1'b1;
    seed = 32'h0ead0bf1;
    repeat (10) @(posedge clk_in);
    #2 reset_n_in = 1'b1;
    repeat (6) @(posedge clk_in);
    // The protect pin is random here: quad enable is on and hides it.
    seed = xs(seed);
    #2 wp_n_in = seed[7];
    check("status_two", s2, 8'h02);
    check("status_one", s1, 8'h00);
    rd(8'h05, 8'hff, 8'h00);
    rd(8'h09, 8'hff, 8'h02);
    rd(8'h35, 8'hff, 8'h02);
    rd(8'h95, 8'hff, 8'h00);
    rd(8'h15, 8'hff, 8'h00);
    check("oe_n", {7'h00, do_oe_n_out}, 8'h01);
    // Status write with the latch clear is refused.
    cmd(40'h01_1800_0000, 2, 0);
    rd(8'h05, 8'hff, 8'h00);
    cmd(40'h06_0000_0000, 1, 0);
    rd(8'h05, 8'hff, 8'h02);
    // The disable command clears the latch; then it is set again.
    cmd(40'h04_0000_0000, 1, 0);
    rd(8'h05, 8'hff, 8'h00);
    cmd(40'h06_0000_0000, 1, 0);
    // Random protect bits, at least one block protect bit set.
    seed = xs(seed);
    v = {1'b0, seed[6:3], 3'b100};
    cmd({8'h01, v, 8'h00, 16'h0}, 3, 0);
    // A held read during the write shows busy and latch.
    q.push_back(16'h0000);
    q.push_back(16'h0000);
    q.push_back(16'h0000);
    q.push_back(16'h0303);
    cmd(40'h05_0000_0000, 1, 4);
    idle();
    rd(8'h05, 8'hff, v);
    check("status_one", s1, v);
    rd(8'h35, 8'hff, 8'h00);
    // Chip erase, and an erase at the protected end, are refused.
    cmd(40'h06_0000_0000, 1, 0);
    cmd(40'hc7_0000_0000, 1, 0);
    rd(8'h05, 8'hfd, v);
    cmd({8'h20, (v[5] ? 24'h000000 : 24'hffffff), 8'h00}, 4, 0);
    rd(8'h05, 8'hff, v | 8'h02);
    // With quad enable on the pin is ignored; with it off it freezes.
    wrs(v | 8'h80, 8'h02);
    #2 wp_n_in = 1'b0;
    wrs(v | 8'h80, 8'h00);
    rd(8'h35, 8'hff, 8'h00);
    wrs(8'h00, 8'h00);
    rd(8'h05, 8'hfd, v | 8'h80);
    #2 wp_n_in = 1'b1;
    wrs(8'h00, 8'h00);
    rd(8'h05, 8'hff, 8'h00);
    // Erase, suspend and resume.
    cmd(40'h06_0000_0000, 1, 0);
    cmd(40'h20_0000_0000, 4, 0);
    repeat (2) @(posedge clk_in);
    #1 check("busy", {7'h00, busy_out}, 8'h01);
    cmd(40'h75_0000_0000, 1, 0);
    rd(8'h35, 8'hff, 8'h80);
    cmd(40'h7a_0000_0000, 1, 0);
    rd(8'h35, 8'hff, 8'h00);
    idle();
    // Program, suspend and resume.
    cmd(40'h06_0000_0000, 1, 0);
    cmd(40'h02_0000_005a, 5, 0);
    cmd(40'h75_0000_0000, 1, 0);
    rd(8'h35, 8'hff, 8'h04);
    cmd(40'h7a_0000_0000, 1, 0);
    rd(8'h35, 8'hff, 8'h00);
    idle();
    // Every noted read byte must have arrived.
    check("notes_left", 8'(q.size()), 8'h00);
    end_sim();
  end
endmodule
